/* ptp_ts_pkg.sv */
// constants of the receive timestamp classifier and time adjust block
// assumes a 32-bit apb slave port and a byte-wide receive message stream
`default_nettype none

package ptp_ts_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_TIME_INC = 8'h04;
	localparam logic [7:0] OFS_SYS_LOW = 8'h08;
	localparam logic [7:0] OFS_SYS_HIGH = 8'h0C;
	localparam logic [7:0] OFS_ADJ_LOW = 8'h10;
	localparam logic [7:0] OFS_ADJ_HIGH = 8'h14;
	localparam logic [7:0] OFS_STAMP_LOW = 8'h18;
	localparam logic [7:0] OFS_STAMP_HIGH = 8'h1C;
	localparam logic [7:0] OFS_STAMP_ID = 8'h20;
	localparam logic [7:0] OFS_STATUS = 8'h24;
	// control fields: bit 0 enable, bit 1 version 2 mode, bits 15:8 message value
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_V2_BIT = 1;
	localparam int CTRL_MSG_LSB = 8;
	// time increment fields: step in 23:0, period in 31:24
	localparam int INC_STEP_LSB = 0;
	localparam int INC_PER_LSB = 24;
	// adjust high: sign in the top bit, magnitude below it
	localparam int ADJ_SIGN_BIT = 31;
	// reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] TIME_INC_RST = 32'h0000_0000;
	// byte positions inside the ptp message
	localparam logic [5:0] BYTE_MSGID = 6'h00;
	localparam logic [5:0] BYTE_VERSION = 6'h01;
	localparam logic [5:0] BYTE_SRC_PORT = 6'h1C;
	localparam logic [5:0] BYTE_SEQ_ID = 6'h1E;
	localparam logic [5:0] BYTE_CONTROL = 6'h20;
	// transport of the message, as reported by the receive datapath
	localparam logic [1:0] XPORT_NONE = 2'h0;
	localparam logic [1:0] XPORT_L2 = 2'h1;
	localparam logic [1:0] XPORT_UDP4 = 2'h2;
	localparam logic [1:0] XPORT_UDP6 = 2'h3;
	// version field values
	localparam logic [3:0] VER_1 = 4'h1;
	localparam logic [3:0] VER_2 = 4'h2;
	// version 1 control codes, 5 and up reserved
	localparam logic [7:0] V1_SYNC = 8'h00;
	localparam logic [7:0] V1_DELAY_REQ = 8'h01;
	localparam logic [7:0] V1_FOLLOW_UP = 8'h02;
	localparam logic [7:0] V1_DELAY_RESP = 8'h03;
	localparam logic [7:0] V1_MANAGEMENT = 8'h04;
	// version 2 message identifiers, 4-7 and e-f unused
	localparam logic [3:0] V2_SYNC = 4'h0;
	localparam logic [3:0] V2_DELAY_REQ = 4'h1;
	localparam logic [3:0] V2_PATH_REQ = 4'h2;
	localparam logic [3:0] V2_PATH_RESP = 4'h3;
	localparam logic [3:0] V2_FOLLOW_UP = 4'h8;
	localparam logic [3:0] V2_DELAY_RESP = 4'h9;
	localparam logic [3:0] V2_PATH_FOLLOW = 4'hA;
	localparam logic [3:0] V2_ANNOUNCE = 4'hB;
	localparam logic [3:0] V2_SIGNALLING = 4'hC;
	localparam logic [3:0] V2_MANAGEMENT = 4'hD;
endpackage : ptp_ts_pkg

`default_nettype wire

/* ptp_class_if.sv */
// link between the message classifier and the time core
// assumes both ends share clk_sys
`default_nettype none

interface ptp_class_if;
	logic cfg_v2; // version 2 mode selected
	logic [7:0] cfg_msg; // configured message value
	logic start; // pulse: byte 0 of a message seen
	logic decide; // pulse: classification finished
	logic match; // with decide: timestamp wanted
	logic [3:0] version; // version field of the message
	logic [7:0] msg_type; // control byte or message id
	logic [15:0] src_port; // source port identity
	logic [15:0] seq_id; // sequence identifier
	modport classifier (input cfg_v2, cfg_msg,
		output start, decide, match, version, msg_type, src_port, seq_id);
	modport core (output cfg_v2, cfg_msg,
		input start, decide, match, version, msg_type, src_port, seq_id);
endinterface : ptp_class_if

`default_nettype wire

/* ptp_msg_classifier.sv */
// byte parser that classifies received ptp messages
// assumes the datapath has already marked the frame as ptp and flags byte 0
`default_nettype none

module ptp_msg_classifier
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// receive message stream
	input wire logic msg_valid,
	input wire logic msg_first,
	input wire logic [7:0] msg_data,
	input wire logic [1:0] msg_xport,
	// results toward the core
	ptp_class_if.classifier cls
);
	typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_PARSE = 2'b01} parse_e;

	parse_e state_reg, state_next; // parser state
	logic [5:0] cnt_reg, cnt_next; // offset of the next byte
	logic [1:0] xport_reg, xport_next; // transport latched at byte 0
	logic [7:0] id_reg, id_next; // byte 0
	logic [3:0] ver_reg, ver_next; // version nibble
	logic [15:0] src_reg, src_next;
	logic [15:0] seq_reg, seq_next;
	logic [7:0] type_reg, type_next;
	logic decide_reg, decide_next;
	logic match_reg, match_next;
	logic v1_ok, v2_ok, v2_path; // decision terms at the control byte

	// decision terms, evaluated while byte 32 is on the bus
	always_comb
	begin
		// version 1 only over udp on ipv4
		v1_ok = (ver_reg == ptp_ts_pkg::VER_1) && (xport_reg == ptp_ts_pkg::XPORT_UDP4);
		// version 2 over l2 or udp on either ip
		v2_ok = (ver_reg == ptp_ts_pkg::VER_2) && (xport_reg != ptp_ts_pkg::XPORT_NONE);
		v2_path = (id_reg[3:0] == ptp_ts_pkg::V2_PATH_REQ) ||
			(id_reg[3:0] == ptp_ts_pkg::V2_PATH_RESP);
	end

	// next state of the parser
	always_comb
	begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		xport_next = xport_reg;
		id_next = id_reg;
		ver_next = ver_reg;
		src_next = src_reg;
		seq_next = seq_reg;
		type_next = type_reg;
		decide_next = 1'b0;
		match_next = match_reg;
		if (msg_valid && msg_first)
		begin
			// a new message restarts the parse even if one was cut short
			state_next = ST_PARSE;
			cnt_next = 6'h01;
			xport_next = msg_xport;
			id_next = msg_data;
		end
		else if (msg_valid && state_reg == ST_PARSE)
		begin
			cnt_next = cnt_reg + 6'h01;
			if (cnt_reg == ptp_ts_pkg::BYTE_VERSION)
				ver_next = msg_data[3:0];
			if (cnt_reg == ptp_ts_pkg::BYTE_SRC_PORT)
				src_next[15:8] = msg_data;
			if (cnt_reg == ptp_ts_pkg::BYTE_SRC_PORT + 6'h01)
				src_next[7:0] = msg_data;
			if (cnt_reg == ptp_ts_pkg::BYTE_SEQ_ID)
				seq_next[15:8] = msg_data;
			if (cnt_reg == ptp_ts_pkg::BYTE_SEQ_ID + 6'h01)
				seq_next[7:0] = msg_data;
			if (cnt_reg == ptp_ts_pkg::BYTE_CONTROL)
			begin
				// version first, then the type field of that version
				state_next = ST_IDLE;
				decide_next = 1'b1;
				if (v1_ok && !cls.cfg_v2)
				begin
					type_next = msg_data;
					match_next = (msg_data == cls.cfg_msg);
				end
				else if (v2_ok && cls.cfg_v2)
				begin
					type_next = {4'h0, id_reg[3:0]};
					match_next = (id_reg[3:0] == cls.cfg_msg[3:0]) || v2_path;
				end
				else
				begin
					type_next = msg_data;
					match_next = 1'b0;
				end
			end
		end
	end

	// parser registers
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			state_reg <= ST_IDLE;
			cnt_reg <= 6'h00;
			xport_reg <= ptp_ts_pkg::XPORT_NONE;
			id_reg <= 8'h00;
			ver_reg <= 4'h0;
			src_reg <= 16'h0000;
			seq_reg <= 16'h0000;
			type_reg <= 8'h00;
			decide_reg <= 1'b0;
			match_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			xport_reg <= xport_next;
			id_reg <= id_next;
			ver_reg <= ver_next;
			src_reg <= src_next;
			seq_reg <= seq_next;
			type_reg <= type_next;
			decide_reg <= decide_next;
			match_reg <= match_next;
		end
	end

	// start is a handshake pulse, so it may come straight from the inputs
	assign cls.start = msg_valid && msg_first;
	assign cls.decide = decide_reg;
	assign cls.match = match_reg;
	assign cls.version = ver_reg;
	assign cls.msg_type = type_reg;
	assign cls.src_port = src_reg;
	assign cls.seq_id = seq_reg;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	a_v1_needs_udp4: assert property (decide_reg && match_reg && ver_reg == ptp_ts_pkg::VER_1
		|-> xport_reg == ptp_ts_pkg::XPORT_UDP4) else $error("v1 matched off udp4");
	a_v2_path_delay: assert property (state_reg == ST_PARSE && msg_valid && !msg_first &&
		cnt_reg == ptp_ts_pkg::BYTE_CONTROL && v2_ok && cls.cfg_v2 && v2_path
		|=> decide_reg && match_reg) else $error("path delay not stamped");
	a_v1_control_cmp: assert property (state_reg == ST_PARSE && msg_valid && !msg_first &&
		cnt_reg == ptp_ts_pkg::BYTE_CONTROL && v1_ok && !cls.cfg_v2
		|=> match_reg == ($past(msg_data) == $past(cls.cfg_msg)))
		else $error("v1 control compare wrong");
	a_mode_gate: assert property (decide_reg && match_reg |->
		(ver_reg == (cls.cfg_v2 ? ptp_ts_pkg::VER_2 : ptp_ts_pkg::VER_1)))
		else $error("match on wrong version");
endmodule : ptp_msg_classifier

`default_nettype wire

/* ptp_rx_time_core.sv */
// receive ptp timestamp capture, 64-bit system time and signed adjust
// assumes an apb master on clk_sys and a receive stream marked as ptp
//
// Design decisions made here: the APB slave port and the register offsets.
`default_nettype none

module ptp_rx_time_core
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// receive ptp message stream
	input wire logic msg_valid,
	input wire logic msg_first,
	input wire logic [7:0] msg_data,
	input wire logic [1:0] msg_xport,
	// status toward the receive descriptor
	output logic stamp_taken,
	output logic stamp_locked
);
	ptp_class_if cls ();

	logic [31:0] ctrl_reg, ctrl_next; // enable, mode, message value
	logic [31:0] time_increment_config_reg, time_increment_config_next;
	logic [63:0] sys_time_reg, sys_time_next; // system_time_high:system_time_low
	logic [31:0] shadow_high_reg, shadow_high_next; // high half latched by a low read
	logic [31:0] offset_correction_low_reg, offset_correction_low_next;
	logic [31:0] offset_correction_high_reg, offset_correction_high_next;
	logic [7:0] period_cnt_reg, period_cnt_next; // cycles since last increment
	logic [63:0] pend_time_reg, pend_time_next; // time seen at message byte 0
	logic [63:0] stamp_time_reg, stamp_time_next;
	logic [15:0] stamp_src_reg, stamp_src_next;
	logic [15:0] stamp_seq_reg, stamp_seq_next;
	logic [7:0] stamp_type_reg, stamp_type_next;
	logic lock_reg, lock_next; // stamp held for software
	logic taken_reg, taken_next;
	logic [31:0] prdata_reg, prdata_next;
	logic pslverr_reg, pslverr_next;
	logic setup, wr, rd; // apb phases
	logic hit; // address maps to a register
	logic inc_event; // increment this cycle
	logic [63:0] adj_mag; // offset magnitude
	logic [63:0] time_base; // time before adjust

	// classifier sees the configured mode and message value
	assign cls.cfg_v2 = ctrl_reg[ptp_ts_pkg::CTRL_V2_BIT];
	assign cls.cfg_msg = ctrl_reg[ptp_ts_pkg::CTRL_MSG_LSB +: 8];

	ptp_msg_classifier u_class
	(
		.clk_sys(clk_sys),
		.rst(rst),
		.msg_valid(msg_valid),
		.msg_first(msg_first),
		.msg_data(msg_data),
		.msg_xport(msg_xport),
		.cls(cls)
	);

	// apb decode: data is prepared in the setup cycle, so no wait states
	always_comb
	begin
		setup = psel && !penable;
		wr = psel && penable && pwrite;
		rd = psel && penable && !pwrite;
		unique case (paddr)
			ptp_ts_pkg::OFS_CTRL, ptp_ts_pkg::OFS_TIME_INC, ptp_ts_pkg::OFS_SYS_LOW,
			ptp_ts_pkg::OFS_SYS_HIGH, ptp_ts_pkg::OFS_ADJ_LOW, ptp_ts_pkg::OFS_ADJ_HIGH,
			ptp_ts_pkg::OFS_STAMP_LOW, ptp_ts_pkg::OFS_STAMP_HIGH, ptp_ts_pkg::OFS_STAMP_ID,
			ptp_ts_pkg::OFS_STATUS: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end

	// read data and error, registered at the setup cycle
	always_comb
	begin
		prdata_next = prdata_reg;
		pslverr_next = pslverr_reg;
		if (setup)
		begin
			pslverr_next = !hit;
			unique case (paddr)
				ptp_ts_pkg::OFS_CTRL: prdata_next = ctrl_reg;
				ptp_ts_pkg::OFS_TIME_INC: prdata_next = time_increment_config_reg;
				ptp_ts_pkg::OFS_SYS_LOW: prdata_next = sys_time_reg[31:0];
				ptp_ts_pkg::OFS_SYS_HIGH: prdata_next = shadow_high_reg;
				ptp_ts_pkg::OFS_ADJ_LOW: prdata_next = offset_correction_low_reg;
				ptp_ts_pkg::OFS_ADJ_HIGH: prdata_next = offset_correction_high_reg;
				ptp_ts_pkg::OFS_STAMP_LOW: prdata_next = stamp_time_reg[31:0];
				ptp_ts_pkg::OFS_STAMP_HIGH: prdata_next = stamp_time_reg[63:32];
				ptp_ts_pkg::OFS_STAMP_ID: prdata_next = {stamp_src_reg, stamp_seq_reg};
				ptp_ts_pkg::OFS_STATUS: prdata_next = {16'h0000, stamp_type_reg, 7'h00, lock_reg};
				default: prdata_next = 32'h0000_0000;
			endcase
		end
	end

	// configuration and adjust registers
	always_comb
	begin
		ctrl_next = ctrl_reg;
		time_increment_config_next = time_increment_config_reg;
		offset_correction_low_next = offset_correction_low_reg;
		offset_correction_high_next = offset_correction_high_reg;
		shadow_high_next = shadow_high_reg;
		if (wr && paddr == ptp_ts_pkg::OFS_CTRL)
			ctrl_next = pwdata;
		if (wr && paddr == ptp_ts_pkg::OFS_TIME_INC)
			time_increment_config_next = pwdata;
		if (wr && paddr == ptp_ts_pkg::OFS_ADJ_LOW)
			offset_correction_low_next = pwdata;
		if (wr && paddr == ptp_ts_pkg::OFS_ADJ_HIGH)
			offset_correction_high_next = pwdata;
		// a low read freezes the high half in the same cycle that loads the low
		// word, so a carry between setup and access cannot split the pair
		if (setup && paddr == ptp_ts_pkg::OFS_SYS_LOW)
			shadow_high_next = sys_time_reg[63:32];
	end

	// system time: free running, increment plus one-shot signed adjust
	always_comb
	begin
		period_cnt_next = period_cnt_reg;
		inc_event = 1'b0;
		// a period of zero stops the clock, one increments every cycle
		if (time_increment_config_reg[ptp_ts_pkg::INC_PER_LSB +: 8] != 8'h00)
		begin
			if (period_cnt_reg + 8'h01 >= time_increment_config_reg[ptp_ts_pkg::INC_PER_LSB +: 8])
			begin
				inc_event = 1'b1;
				period_cnt_next = 8'h00;
			end
			else
				period_cnt_next = period_cnt_reg + 8'h01;
		end
		time_base = sys_time_reg;
		if (inc_event)
			time_base = sys_time_reg +
				{40'h00_0000_0000, time_increment_config_reg[ptp_ts_pkg::INC_STEP_LSB +: 24]};
		// the low word was written earlier, the high write triggers the add
		adj_mag = {1'b0, pwdata[ptp_ts_pkg::ADJ_SIGN_BIT - 1:0], offset_correction_low_reg};
		sys_time_next = time_base;
		if (wr && paddr == ptp_ts_pkg::OFS_ADJ_HIGH)
		begin
			if (pwdata[ptp_ts_pkg::ADJ_SIGN_BIT])
				sys_time_next = time_base - adj_mag;
			else
				sys_time_next = time_base + adj_mag;
		end
		// direct writes set a half outright and override the step
		if (wr && paddr == ptp_ts_pkg::OFS_SYS_LOW)
			sys_time_next[31:0] = pwdata;
		if (wr && paddr == ptp_ts_pkg::OFS_SYS_HIGH)
			sys_time_next[63:32] = pwdata;
	end

	// receive stamp capture and lock
	always_comb
	begin
		pend_time_next = cls.start ? sys_time_reg : pend_time_reg;
		stamp_time_next = stamp_time_reg;
		stamp_src_next = stamp_src_reg;
		stamp_seq_next = stamp_seq_reg;
		stamp_type_next = stamp_type_reg;
		taken_next = 1'b0;
		lock_next = lock_reg;
		// reading the high stamp word releases the lock
		if (rd && paddr == ptp_ts_pkg::OFS_STAMP_HIGH)
			lock_next = 1'b0;
		// a new match while locked is dropped, also in the cycle of the releasing read
		if (cls.decide && cls.match && ctrl_reg[ptp_ts_pkg::CTRL_EN_BIT] && !lock_reg)
		begin
			stamp_time_next = pend_time_reg;
			stamp_src_next = cls.src_port;
			stamp_seq_next = cls.seq_id;
			stamp_type_next = cls.msg_type;
			taken_next = 1'b1;
			lock_next = 1'b1;
		end
	end

	// all state of the core
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			ctrl_reg <= ptp_ts_pkg::CTRL_RST;
			time_increment_config_reg <= ptp_ts_pkg::TIME_INC_RST;
			sys_time_reg <= 64'h0000_0000_0000_0000;
			shadow_high_reg <= 32'h0000_0000;
			offset_correction_low_reg <= 32'h0000_0000;
			offset_correction_high_reg <= 32'h0000_0000;
			period_cnt_reg <= 8'h00;
			pend_time_reg <= 64'h0000_0000_0000_0000;
			stamp_time_reg <= 64'h0000_0000_0000_0000;
			stamp_src_reg <= 16'h0000;
			stamp_seq_reg <= 16'h0000;
			stamp_type_reg <= 8'h00;
			lock_reg <= 1'b0;
			taken_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end
		else
		begin
			ctrl_reg <= ctrl_next;
			time_increment_config_reg <= time_increment_config_next;
			sys_time_reg <= sys_time_next;
			shadow_high_reg <= shadow_high_next;
			offset_correction_low_reg <= offset_correction_low_next;
			offset_correction_high_reg <= offset_correction_high_next;
			period_cnt_reg <= period_cnt_next;
			pend_time_reg <= pend_time_next;
			stamp_time_reg <= stamp_time_next;
			stamp_src_reg <= stamp_src_next;
			stamp_seq_reg <= stamp_seq_next;
			stamp_type_reg <= stamp_type_next;
			lock_reg <= lock_next;
			taken_reg <= taken_next;
			prdata_reg <= prdata_next;
			pslverr_reg <= pslverr_next;
		end
	end

	// outputs
	assign prdata = prdata_reg;
	assign pready = 1'b1;
	assign pslverr = pslverr_reg && psel && penable;
	assign stamp_taken = taken_reg;
	assign stamp_locked = lock_reg;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_adj_write;
		wr && paddr == ptp_ts_pkg::OFS_ADJ_HIGH && !pwdata[31] && !inc_event;
	endsequence
	sequence s_lock_set;
		!lock_reg ##1 lock_reg;
	endsequence

	a_adjust_add: assert property (s_adj_write |=> sys_time_reg ==
		$past(sys_time_reg) + {1'b0, $past(pwdata[30:0]), $past(offset_correction_low_reg)})
		else $error("positive adjust not added");
	a_adjust_sub: assert property (wr && paddr == ptp_ts_pkg::OFS_ADJ_HIGH && pwdata[31] &&
		!inc_event |=> sys_time_reg == $past(sys_time_reg) -
		{1'b0, $past(pwdata[30:0]), $past(offset_correction_low_reg)})
		else $error("negative adjust not subtracted");
	a_time_step: assert property (inc_event && !wr |=> sys_time_reg == $past(sys_time_reg) +
		{40'h00_0000_0000, $past(time_increment_config_reg[23:0])})
		else $error("increment step wrong");
	a_time_holds: assert property (!inc_event && !wr |=> $stable(sys_time_reg))
		else $error("time moved without event");
	a_capture_values: assert property (s_lock_set |-> stamp_time_reg == $past(pend_time_reg) &&
		stamp_seq_reg == $past(cls.seq_id) && stamp_src_reg == $past(cls.src_port))
		else $error("capture values wrong");
	a_lock_holds: assert property (lock_reg && !(rd && paddr == ptp_ts_pkg::OFS_STAMP_HIGH)
		|=> lock_reg && $stable(stamp_time_reg) && $stable(stamp_seq_reg))
		else $error("locked stamp changed");
	a_release_read: assert property (lock_reg && rd && paddr == ptp_ts_pkg::OFS_STAMP_HIGH &&
		!cls.decide |=> !lock_reg) else $error("read did not release");
endmodule : ptp_rx_time_core

`default_nettype wire

/* ptp_rx_stream_model.sv */
// receive datapath stand-in: streams one ptp message per call
// assumes the frame was already marked as ptp upstream, on clk_sys
`default_nettype none

module ptp_rx_stream_model
(
	// clock
	input wire logic clk_sys,
	// message stream toward the block
	output logic msg_valid,
	output logic msg_first,
	output logic [7:0] msg_data,
	output logic [1:0] msg_xport
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle stream at time zero
	initial
	begin
		msg_valid = 1'b0;
		msg_first = 1'b0;
		msg_data = 8'h00;
		msg_xport = 2'h0;
	end

	// 36 bytes; slow puts an idle cycle after each byte
	task automatic send(input logic [1:0] xp, input logic [3:0] ver, input logic [7:0] b0,
		input logic [7:0] ctl, input logic [31:0] ids, input bit slow);
		logic [7:0] b;
		for (int i = 0; i < 36; i++)
		begin
			case (i)
				0: b = b0;
				1: b = {4'h0, ver};
				28: b = ids[31:24];
				29: b = ids[23:16];
				30: b = ids[15:8];
				31: b = ids[7:0];
				32: b = ctl;
				default: b = 8'(8'h5A + i); // filler
			endcase
			@(posedge clk_sys);
			msg_valid <= 1'b1;
			msg_first <= (i == 0);
			msg_data <= b;
			msg_xport <= xp;
			if (slow)
			begin
				@(posedge clk_sys);
				msg_valid <= 1'b0;
				msg_first <= 1'b0;
				msg_data <= ~b; // no stale byte on the lines
			end
		end
		@(posedge clk_sys);
		msg_valid <= 1'b0;
		msg_first <= 1'b0;
		msg_data <= ~b;
	endtask : send
endmodule : ptp_rx_stream_model

`default_nettype wire

/* tb_top.sv */
// self-checking bench of the receive timestamp and time adjust block
// assumes ptp_ts_pkg and the stream model are compiled first
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	// clock, reset and apb master
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	// stream and status
	logic msg_valid;
	logic msg_first;
	logic [7:0] msg_data;
	logic [1:0] msg_xport;
	logic stamp_taken;
	logic stamp_locked;
	// bookkeeping
	int miscompares = 0;
	int checks = 0;
	int takes = 0;
	logic [31:0] rdv;
	logic errv;

	always #12.5 clk_sys = ~clk_sys;

	// counts stamp pulses; a pulse is one cycle wide
	always @(posedge clk_sys)
		if (stamp_taken === 1'b1)
			takes <= takes + 1;

	ptp_rx_time_core ptp_rx_time_core_i (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .msg_valid, .msg_first, .msg_data, .msg_xport,
		.stamp_taken, .stamp_locked);
	ptp_rx_stream_model ptp_rx_stream_model_i (.clk_sys, .msg_valid, .msg_first, .msg_data,
		.msg_xport);

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	// one apb transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk_sys);
		penable <= 1'b1;
		do
			@(posedge clk_sys);
		while (pready !== 1'b1);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0000_0000);
	endtask : rd

	// control word: enable set, version mode and message value
	function automatic logic [31:0] cfg(input int v2, input logic [7:0] m);
		return {16'h0000, m, 6'h00, v2[0], 1'b1};
	endfunction : cfg

	task automatic test_reset;
		rd(ptp_ts_pkg::OFS_CTRL);
		check(rdv, ptp_ts_pkg::CTRL_RST);
		rd(ptp_ts_pkg::OFS_TIME_INC);
		check(rdv, ptp_ts_pkg::TIME_INC_RST);
		check(errv, 1'b0);
		rd(8'h40); // unmapped: refused
		check(errv, 1'b1);
		check(rdv, 32'h0000_0000);
		$display("reset test done");
	endtask : test_reset

	// low word first, then high word fires the signed add
	task automatic adj(input logic [31:0] lo, input logic [31:0] hi, input logic [63:0] exp);
		apb(1'b1, ptp_ts_pkg::OFS_ADJ_LOW, lo);
		apb(1'b1, ptp_ts_pkg::OFS_ADJ_HIGH, hi);
		rd(ptp_ts_pkg::OFS_SYS_LOW);
		check(rdv, exp[31:0]);
		rd(ptp_ts_pkg::OFS_SYS_HIGH);
		check(rdv, exp[63:32]);
	endtask : adj

	task automatic test_adjust;
		apb(1'b1, ptp_ts_pkg::OFS_SYS_LOW, 32'hFFFF_FFFF);
		apb(1'b1, ptp_ts_pkg::OFS_SYS_HIGH, 32'h0000_0005);
		adj(32'h0000_0001, 32'h0000_0000, 64'h0000_0006_0000_0000);
		adj(32'h0000_0002, 32'h8000_0000, 64'h0000_0005_FFFF_FFFE);
		adj(32'h0000_0000, 32'h0000_0003, 64'h0000_0008_FFFF_FFFE);
		$display("adjust test done");
	endtask : test_adjust

	// reads are three cycles apart, so period 1 gives 3 steps, period 3 one
	task automatic test_count;
		logic [31:0] t;
		apb(1'b1, ptp_ts_pkg::OFS_TIME_INC, {8'h01, 24'h00_0003});
		rd(ptp_ts_pkg::OFS_SYS_LOW);
		t = rdv;
		rd(ptp_ts_pkg::OFS_SYS_LOW);
		check(rdv - t, 32'h0000_0009);
		apb(1'b1, ptp_ts_pkg::OFS_TIME_INC, {8'h03, 24'h00_0007});
		rd(ptp_ts_pkg::OFS_SYS_LOW);
		t = rdv;
		rd(ptp_ts_pkg::OFS_SYS_LOW);
		check(rdv - t, 32'h0000_0007);
		apb(1'b1, ptp_ts_pkg::OFS_TIME_INC, 32'h0000_0000); // halt for stamp checks
		$display("count test done");
	endtask : test_count

	// one message; time is halted so the stamp equals the time read before
	task automatic msg(input logic [31:0] c, input logic [1:0] xp, input logic [3:0] ver,
		input logic [7:0] b0, input logic [7:0] ct, input int exp, input int slow);
		logic [31:0] t;
		logic [31:0] ids;
		int n;
		apb(1'b1, ptp_ts_pkg::OFS_CTRL, c);
		rd(ptp_ts_pkg::OFS_SYS_LOW);
		t = rdv;
		ids = {8'h3C, b0, 8'h71, ct};
		n = takes;
		ptp_rx_stream_model_i.send(xp, ver, b0, ct, ids, slow[0]);
		repeat (3) @(posedge clk_sys);
		#1;
		check(takes - n, exp);
		check(stamp_locked, exp);
		if (exp != 0)
		begin
			rd(ptp_ts_pkg::OFS_STAMP_ID);
			check(rdv, ids);
			rd(ptp_ts_pkg::OFS_STAMP_LOW);
			check(rdv, t);
			// status: lock set, type is the v1 control byte or the v2 identifier
			rd(ptp_ts_pkg::OFS_STATUS);
			check(rdv, {16'h0000, (c[1] ? {4'h0, b0[3:0]} : ct), 7'h00, 1'b1});
			rd(ptp_ts_pkg::OFS_STAMP_HIGH);
			#1;
			check(stamp_locked, 1'b0);
		end
	endtask : msg

	task automatic test_class;
		for (int k = 0; k < 5; k++)
			msg(cfg(0, 8'(k)), ptp_ts_pkg::XPORT_UDP4, ptp_ts_pkg::VER_1, 8'h00, 8'(k), 1, 0);
		msg(cfg(0, 8'h01), ptp_ts_pkg::XPORT_L2, ptp_ts_pkg::VER_1, 8'h00, 8'h01, 0, 0);
		msg(cfg(0, 8'h01), ptp_ts_pkg::XPORT_UDP6, ptp_ts_pkg::VER_1, 8'h00, 8'h01, 0, 0);
		msg(cfg(0, 8'h02), ptp_ts_pkg::XPORT_UDP4, ptp_ts_pkg::VER_1, 8'h02, 8'h03, 0, 0);
		msg(cfg(0, 8'h00), ptp_ts_pkg::XPORT_UDP4, ptp_ts_pkg::VER_2, 8'h00, 8'h00, 0, 0);
		msg(cfg(1, 8'h00), ptp_ts_pkg::XPORT_UDP4, ptp_ts_pkg::VER_1, 8'h00, 8'h00, 0, 0);
		// stamping disabled: an otherwise matching v1 message is not stamped
		msg(32'h0000_0100, ptp_ts_pkg::XPORT_UDP4, ptp_ts_pkg::VER_1, 8'h00, 8'h01, 0, 0);
		for (int k = 0; k < 14; k++)
			if (k < 4 || k > 7)
				msg(cfg(1, 8'(k)), ptp_ts_pkg::XPORT_L2, ptp_ts_pkg::VER_2, 8'(k), 8'hFF, 1, k[0]);
		msg(cfg(1, 8'h09), ptp_ts_pkg::XPORT_UDP4, ptp_ts_pkg::VER_2, 8'h09, 8'h00, 1, 0);
		msg(cfg(1, 8'h01), ptp_ts_pkg::XPORT_UDP6, ptp_ts_pkg::VER_2, 8'h01, 8'h00, 1, 0);
		msg(cfg(1, 8'h00), ptp_ts_pkg::XPORT_NONE, ptp_ts_pkg::VER_2, 8'h00, 8'h00, 0, 0);
		msg(cfg(1, 8'h08), ptp_ts_pkg::XPORT_L2, ptp_ts_pkg::VER_2, 8'h09, 8'h08, 0, 0);
		msg(cfg(1, 8'h08), ptp_ts_pkg::XPORT_L2, ptp_ts_pkg::VER_2, 8'h02, 8'h08, 1, 0);
		msg(cfg(1, 8'h0B), ptp_ts_pkg::XPORT_UDP6, ptp_ts_pkg::VER_2, 8'h03, 8'h0B, 1, 1);
		$display("classify test done");
	endtask : test_class

	// a second match while locked must leave the first stamp alone
	task automatic test_lock;
		int n;
		apb(1'b1, ptp_ts_pkg::OFS_CTRL, cfg(1, 8'h00));
		n = takes;
		ptp_rx_stream_model_i.send(ptp_ts_pkg::XPORT_L2, ptp_ts_pkg::VER_2, 8'h00, 8'h00,
			32'h1111_2222, 1'b0);
		ptp_rx_stream_model_i.send(ptp_ts_pkg::XPORT_L2, ptp_ts_pkg::VER_2, 8'h00, 8'h00,
			32'h3333_4444, 1'b0);
		repeat (3) @(posedge clk_sys);
		#1;
		check(takes - n, 1);
		rd(ptp_ts_pkg::OFS_STAMP_ID);
		check(rdv, 32'h1111_2222);
		rd(ptp_ts_pkg::OFS_STAMP_HIGH);
		$display("lock test done");
	endtask : test_lock

	task automatic print_verdict;
		$display("counts: %0d checks, %0d miscompares", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : print_verdict

	// main sequence
	initial
	begin
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		test_reset();
		test_adjust();
		test_count();
		test_class();
		test_lock();
		print_verdict();
	end

	// watchdog: the whole run needs well under 10000 cycles
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		miscompares++;
		print_verdict();
	end
endmodule : tb_top

`default_nettype wire
